// ### logic/peci_pkg.sv
package peci_pkg;

	// ==========================================================================
	// Geometry
	localparam int PECI_NPORT = 4;
	localparam int PECI_PIN_W = 8;
	localparam int PECI_ALL_W = PECI_NPORT * PECI_PIN_W;
	localparam int PECI_ADDR_W = 7;

	// ==========================================================================
	// Register map (byte addresses)
	localparam logic [3:0] PECI_OFS_RISE = 4'h0;
	localparam logic [3:0] PECI_OFS_FALL = 4'h4;
	localparam logic [3:0] PECI_OFS_FLAGS = 4'h8;
	localparam logic [6:0] PECI_ADDR_CTRL = 7'h40;
	localparam logic [6:0] PECI_ADDR_EVT_STATUS = 7'h44;
	localparam logic [6:0] PECI_ADDR_EVT_CLEAR = 7'h48;
	localparam logic [6:0] PECI_ADDR_EVT_ENABLE = 7'h4c;
	localparam int PECI_CTRL_MASTER_BIT = 0;
	localparam int PECI_CTRL_SUMMARY_BIT = 1;

	// ==========================================================================
	// Reset values and implemented-bit masks; port index 3 is port E.
	localparam logic [7:0] PECI_REG_RESET = 8'h00;
	localparam logic [3:0] PECI_EVT_RESET = 4'h0;
	localparam logic [PECI_NPORT-1:0][PECI_PIN_W-1:0] PECI_PORT_MASK = {
		8'h08, 8'hff, 8'hff, 8'hff
	};

	// ==========================================================================
	// Bus answers and captured write request
	localparam logic [1:0] PECI_RESP_OKAY = 2'h0;
	localparam logic [1:0] PECI_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [PECI_ADDR_W-1:0] addr;
		logic [31:0]            data;
		logic [3:0]             strb;
	} peci_wreq_t;

endpackage

// ### logic/peci_edge_det.sv
`timescale 1ns/10ps
module peci_edge_det
	import peci_pkg::*;
#(
	parameter int W = PECI_ALL_W
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Pins and edge pulses
	input  wire logic [W-1:0] pins,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	// ==========================================================================
	// Synchroniser; only the second stage feeds the comparison.
	logic [W-1:0] sync1_reg;
	logic [W-1:0] sync2_reg;
	logic [W-1:0] prev_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= '0;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign rise = sync2_reg & ~prev_reg;
	assign fall = ~sync2_reg & prev_reg;

endmodule

// ### logic/peci_top.sv
// Contract
// - Every implemented pin of every port can be an edge-change source, in any combination.
// - Each pin has separate rising and falling edge detectors.
// - Rising detection on a pin works only while its rise enable bit is one.
// - Falling detection on a pin works only while its fall enable bit is one.
// - Both enables set means both directions are detected.
// - A pin with both enables zero never gets its flag set by hardware.
// - Enabled rising or falling transition sets that pin's flag bit.
// - An enabled edge raises the interrupt only while the master enable is one.
// - With master enable zero, flags still set but no interrupt results.
// - Summary flag is the OR of all per-pin flags.
// - Writing zero to a flag bit clears it.
// - An edge during a flag write leaves the flag set regardless of data.
// - An enabled edge wakes the device from sleep when master enable is one.
// - Each port has an 8-bit read/write rise enable register, reset zero.
// - Each port has an 8-bit read/write fall enable register, reset zero.
// - Each port has an 8-bit flag register, software and hardware writable, reset zero.
// - Port E implements only bit 3; other bits read zero.
`timescale 1ns/10ps
module peci_top
	import peci_pkg::*;
(
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// Port pins
	input  wire logic [PECI_PIN_W-1:0]  port_a_pin,
	input  wire logic [PECI_PIN_W-1:0]  port_b_pin,
	input  wire logic [PECI_PIN_W-1:0]  port_c_pin,
	input  wire logic [PECI_PIN_W-1:0]  port_e_pin,
	// AXI4-Lite write address and data
	input  wire logic [PECI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read
	input  wire logic [PECI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Interrupt and wake
	output logic                        irq,
	output logic                        ioc_summary_flag,
	output logic                        wake_pulse
);

	// ==========================================================================
	// Edge detection
	logic [PECI_ALL_W-1:0] pins_all;
	logic [PECI_ALL_W-1:0] rise_det;
	logic [PECI_ALL_W-1:0] fall_det;

	assign pins_all = {port_e_pin, port_c_pin, port_b_pin, port_a_pin};

	peci_edge_det #(
		.W (PECI_ALL_W)
	) peci_edge_det_inst (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pins    (pins_all),
		.rise    (rise_det),
		.fall    (fall_det)
	);

	// ==========================================================================
	// Write channel capture
	peci_wreq_t wreq_reg;
	logic       aw_got_reg;
	logic       aw_got_next;
	logic       w_got_reg;
	logic       w_got_next;
	logic       aw_take;
	logic       w_take;
	logic       do_write;
	logic       awready_reg;
	logic       wready_reg;
	logic       bvalid_reg;
	logic [1:0] bresp_reg;

	assign aw_take = s_axi_awvalid & awready_reg;
	assign w_take = s_axi_wvalid & wready_reg;
	// The response slot must be free, so at most one write is under way.
	assign do_write = aw_got_reg & w_got_reg & ~bvalid_reg;

	always_comb begin
		aw_got_next = (aw_got_reg | aw_take) & ~do_write;
		w_got_next = (w_got_reg | w_take) & ~do_write;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			wreq_reg    <= '0;
		end else begin
			aw_got_reg  <= aw_got_next;
			w_got_reg   <= w_got_next;
			awready_reg <= ~aw_got_next;
			wready_reg  <= ~w_got_next;
			if (aw_take) begin
				wreq_reg.addr <= s_axi_awaddr;
			end
			if (w_take) begin
				wreq_reg.data <= s_axi_wdata;
				wreq_reg.strb <= s_axi_wstrb;
			end
		end
	end

	// ==========================================================================
	// Write decode
	logic                  wr_port_space;
	logic [1:0]            wr_port;
	logic                  wr_mapped;
	logic [PECI_PIN_W-1:0] wr_byte;

	assign wr_port_space = ~wreq_reg.addr[6];
	assign wr_port = wreq_reg.addr[5:4];
	assign wr_byte = wreq_reg.data[PECI_PIN_W-1:0];

	always_comb begin
		wr_mapped = 1'b0;
		if (wr_port_space) begin
			wr_mapped = (wreq_reg.addr[3:0] == PECI_OFS_RISE)
				| (wreq_reg.addr[3:0] == PECI_OFS_FALL)
				| (wreq_reg.addr[3:0] == PECI_OFS_FLAGS);
		end else begin
			wr_mapped = (wreq_reg.addr == PECI_ADDR_CTRL)
				| (wreq_reg.addr == PECI_ADDR_EVT_STATUS)
				| (wreq_reg.addr == PECI_ADDR_EVT_CLEAR)
				| (wreq_reg.addr == PECI_ADDR_EVT_ENABLE);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= PECI_RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? PECI_RESP_OKAY : PECI_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ==========================================================================
	// Per-port enable and flag registers
	logic [PECI_PIN_W-1:0] rise_en_reg [PECI_NPORT];
	logic [PECI_PIN_W-1:0] fall_en_reg [PECI_NPORT];
	logic [PECI_PIN_W-1:0] flags_reg [PECI_NPORT];
	logic [PECI_PIN_W-1:0] set_vec [PECI_NPORT];
	logic [PECI_NPORT-1:0] flag_wr;
	logic [PECI_NPORT-1:0] port_hit;
	logic                  byte0_wr;

	// Byte lane 0 carries every implemented bit; other lanes are ignored.
	assign byte0_wr = do_write & wreq_reg.strb[0] & wr_port_space;

	for (genvar p = 0; p < PECI_NPORT; p++) begin : g_port
		localparam logic [PECI_PIN_W-1:0] MASK = PECI_PORT_MASK[p];
		localparam logic [1:0] IDX = 2'(p);

		assign port_hit[p] = byte0_wr & (wr_port == IDX);
		assign flag_wr[p] = port_hit[p] & (wreq_reg.addr[3:0] == PECI_OFS_FLAGS);
		assign set_vec[p] = ((rise_det[p*PECI_PIN_W +: PECI_PIN_W] & rise_en_reg[p])
			| (fall_det[p*PECI_PIN_W +: PECI_PIN_W] & fall_en_reg[p])) & MASK;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rise_en_reg[p] <= PECI_REG_RESET;
				fall_en_reg[p] <= PECI_REG_RESET;
			end else begin
				if (port_hit[p] && wreq_reg.addr[3:0] == PECI_OFS_RISE) begin
					rise_en_reg[p] <= wr_byte & MASK;
				end
				if (port_hit[p] && wreq_reg.addr[3:0] == PECI_OFS_FALL) begin
					fall_en_reg[p] <= wr_byte & MASK;
				end
			end
		end

		// A hardware set in the same cycle as a software write always wins.
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				flags_reg[p] <= PECI_REG_RESET;
			end else begin
				flags_reg[p] <= ((flag_wr[p] ? wr_byte : flags_reg[p]) & MASK)
					| set_vec[p];
			end
		end
	end

	// ==========================================================================
	// Control, event status and interrupt
	logic                  master_reg;
	logic [PECI_NPORT-1:0] evt_status_reg;
	logic [PECI_NPORT-1:0] evt_enable_reg;
	logic [PECI_NPORT-1:0] port_set;
	logic [PECI_NPORT-1:0] evt_clear;
	logic                  flags_any;
	logic                  set_any;
	logic                  ctrl_wr;
	logic                  irq_reg;
	logic                  summary_reg;
	logic                  wake_reg;

	always_comb begin
		flags_any = 1'b0;
		for (int p = 0; p < PECI_NPORT; p++) begin
			flags_any = flags_any | (|flags_reg[p]);
			port_set[p] = |set_vec[p];
		end
	end

	assign set_any = |port_set;
	assign ctrl_wr = do_write & wreq_reg.strb[0];
	assign evt_clear = (ctrl_wr && wreq_reg.addr == PECI_ADDR_EVT_CLEAR)
		? wreq_reg.data[PECI_NPORT-1:0] : PECI_EVT_RESET;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			master_reg     <= 1'b0;
			evt_enable_reg <= PECI_EVT_RESET;
		end else begin
			if (ctrl_wr && wreq_reg.addr == PECI_ADDR_CTRL) begin
				master_reg <= wreq_reg.data[PECI_CTRL_MASTER_BIT];
			end
			if (ctrl_wr && wreq_reg.addr == PECI_ADDR_EVT_ENABLE) begin
				evt_enable_reg <= wreq_reg.data[PECI_NPORT-1:0];
			end
		end
	end

	// Detection runs whatever the master enable; it only gates irq and wake_pulse, not the summary flag.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_status_reg <= PECI_EVT_RESET;
		end else begin
			evt_status_reg <= (evt_status_reg & ~evt_clear) | port_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_reg     <= 1'b0;
			summary_reg <= 1'b0;
			wake_reg    <= 1'b0;
		end else begin
			irq_reg     <= master_reg & (|(evt_status_reg & evt_enable_reg));
			summary_reg <= flags_any;
			wake_reg    <= master_reg & set_any;
		end
	end

	// ==========================================================================
	// Read channel
	logic        ar_take;
	logic        rvalid_next;
	logic        arready_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic [31:0] rd_word;
	logic [1:0]  rd_resp;

	assign ar_take = s_axi_arvalid & arready_reg;
	assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);

	always_comb begin
		rd_word = '0;
		rd_resp = PECI_RESP_OKAY;
		if (!s_axi_araddr[6]) begin
			unique case (s_axi_araddr[3:0])
				PECI_OFS_RISE:  rd_word[PECI_PIN_W-1:0] = rise_en_reg[s_axi_araddr[5:4]];
				PECI_OFS_FALL:  rd_word[PECI_PIN_W-1:0] = fall_en_reg[s_axi_araddr[5:4]];
				PECI_OFS_FLAGS: rd_word[PECI_PIN_W-1:0] = flags_reg[s_axi_araddr[5:4]];
				default:        rd_resp = PECI_RESP_SLVERR;
			endcase
		end else begin
			unique case (s_axi_araddr)
				PECI_ADDR_CTRL: begin
					rd_word[PECI_CTRL_MASTER_BIT] = master_reg;
					rd_word[PECI_CTRL_SUMMARY_BIT] = summary_reg;
				end
				PECI_ADDR_EVT_STATUS: rd_word[PECI_NPORT-1:0] = evt_status_reg;
				PECI_ADDR_EVT_CLEAR:  rd_word = '0;
				PECI_ADDR_EVT_ENABLE: rd_word[PECI_NPORT-1:0] = evt_enable_reg;
				default:              rd_resp = PECI_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= PECI_RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg  <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_resp;
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign irq = irq_reg;
	assign ioc_summary_flag = summary_reg;
	assign wake_pulse = wake_reg;

	// ==========================================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [PECI_PIN_W-1:0] flags_a;
	logic [PECI_PIN_W-1:0] set_a;
	logic [PECI_PIN_W-1:0] both_off_a;
	logic [PECI_PIN_W-1:0] rise_hit_a;
	logic [PECI_PIN_W-1:0] fall_hit_a;
	logic                  flag_wr_a;

	assign flags_a = flags_reg[0];
	assign set_a = set_vec[0];
	assign flag_wr_a = flag_wr[0];
	assign both_off_a = ~(rise_en_reg[0] | fall_en_reg[0]);
	assign rise_hit_a = rise_det[PECI_PIN_W-1:0] & rise_en_reg[0];
	assign fall_hit_a = fall_det[PECI_PIN_W-1:0] & fall_en_reg[0];

	sequence s_pin_rise;
		!port_a_pin[0] ##1 port_a_pin[0] [*3];
	endsequence

	sequence s_enabled_rise;
		s_pin_rise ##0 rise_en_reg[0][0];
	endsequence

	chk_sync_latency: assert property (s_pin_rise |-> rise_det[0])
		else $error("rising pin not detected two cycles after sampling");
	chk_rise_flag_set: assert property (s_enabled_rise |=> flags_a[0])
		else $error("enabled rising edge did not set flag");
	chk_fall_flag_set: assert property ((fall_hit_a != 0) |=> ((flags_a & $past(fall_hit_a))
		== $past(fall_hit_a)))
		else $error("enabled falling edge did not set flag");
	chk_no_enable_set: assert property (!flag_wr_a |=> ((flags_a & ~$past(flags_a)
		& $past(both_off_a)) == 0))
		else $error("flag set on a pin with both enables off");
	chk_write_clears: assert property ((flag_wr_a && set_a == 0) |=>
		(flags_a == $past(wr_byte)))
		else $error("flag write did not store written value");
	chk_set_wins: assert property ((flag_wr_a && set_a != 0) |=>
		((flags_a & $past(set_a)) == $past(set_a)))
		else $error("edge during flag write was lost");
	chk_irq_master: assert property (!master_reg |=> !irq_reg)
		else $error("interrupt raised with master enable off");
	chk_irq_raise: assert property ((master_reg && rise_hit_a != 0 && evt_enable_reg[0])
		|-> ##2 irq_reg)
		else $error("enabled edge did not raise interrupt");
	chk_summary_or: assert property (1'b1 |=> (summary_reg == $past(flags_any)))
		else $error("summary flag not following flag OR");
	chk_wake_pulse: assert property ((master_reg && set_any) |=> wake_reg)
		else $error("enabled edge did not wake");
	chk_porte_mask: assert property (((flags_reg[3] | rise_en_reg[3] | fall_en_reg[3])
		& ~PECI_PORT_MASK[3]) == 0)
		else $error("port E unimplemented bit set");

endmodule

// ### test/peci_pin_model.sv
`timescale 1ns/10ps
module peci_pin_model
	import peci_pkg::*;
(
	// Pin levels seen by the block
	output logic [PECI_PIN_W-1:0] port_a_pin,
	output logic [PECI_PIN_W-1:0] port_b_pin,
	output logic [PECI_PIN_W-1:0] port_c_pin,
	output logic [PECI_PIN_W-1:0] port_e_pin
);
	// ==========================================================================
	// Pin levels
	// Pins start low so that release of reset shows no edge to the block.
	logic [PECI_ALL_W-1:0] lvl = '0;

	assign port_a_pin = lvl[7:0];
	assign port_b_pin = lvl[15:8];
	assign port_c_pin = lvl[23:16];
	assign port_e_pin = lvl[31:24];

	// Levels change only just after a clock edge and stay for many cycles, because a
	// pulse shorter than one cycle may be missed by the block's sampling.
	task automatic drive(input int p, input logic [7:0] v);
		lvl[8*p +: 8] <= v;
	endtask
endmodule

// ### test/test_pin_edge_change_interrupt.sv
`timescale 1ns/10ps
module test_pin_edge_change_interrupt;
	import peci_pkg::*;
	// ==========================================================================
	// Signals
	logic                   aclk = 1'b0;
	logic                   aresetn = 1'b0;
	logic [PECI_PIN_W-1:0]  port_a_pin, port_b_pin, port_c_pin, port_e_pin;
	logic [PECI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]            s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]             s_axi_wstrb = 4'hf;
	logic [1:0]             s_axi_bresp, s_axi_rresp;
	logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                   s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic                   s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                   s_axi_arready, s_axi_rvalid;
	logic                   irq, ioc_summary_flag, wake_pulse;
	logic [33:0]            rq[$];
	logic [1:0]             bq[$];
	int                     num_errors = 0, comparisons = 0, wake_count = 0, cycles = 0;

	always #2 aclk = ~aclk;

	peci_pin_model peci_pin_model_inst (.port_a_pin, .port_b_pin, .port_c_pin, .port_e_pin);

	peci_top peci_top_inst (.aclk, .aresetn, .port_a_pin, .port_b_pin, .port_c_pin,
		.port_e_pin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .ioc_summary_flag, .wake_pulse);

	// ==========================================================================
	// Checking and closing
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// The monitor pairs each bus answer with the oldest expectation noted by the driver.
	always @(posedge aclk) begin
		cycles++;
		if (s_axi_rvalid === 1'b1 && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata},
			rq.pop_front());
		if (s_axi_bvalid === 1'b1 && s_axi_bready) check("bresp", 34'(s_axi_bresp),
			34'(bq.pop_front()));
		if (wake_pulse === 1'b1) wake_count++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	// ==========================================================================
	// Bus master
	function automatic logic [6:0] ra(input int p, input logic [3:0] ofs);
		return 7'(16 * p) + 7'(ofs);
	endfunction

	task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] er);
		bit aw_done, w_done;
		bq.push_back(er);
		aw_done = 0;
		w_done = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw_done && w_done));
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [1:0] er);
		rq.push_back({er, 24'h0, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
	endtask

	// ==========================================================================
	// Tests
	initial begin
		logic [7:0] re, fe, m, seen;
		int w0;
		void'($urandom(32'hca5aa7da));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// Both answer channels stay ready, so back-to-back calls never toggle them.
		s_axi_bready <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int p = 0; p < PECI_NPORT; p++) begin
			rd(ra(p, PECI_OFS_RISE), 8'h00, PECI_RESP_OKAY);
			rd(ra(p, PECI_OFS_FALL), 8'h00, PECI_RESP_OKAY);
			rd(ra(p, PECI_OFS_FLAGS), 8'h00, PECI_RESP_OKAY);
		end
		rd(7'h3c, 8'h00, PECI_RESP_SLVERR);
		wr(7'h50, 32'hff, PECI_RESP_SLVERR);
		wr(PECI_ADDR_EVT_ENABLE, 32'hf, PECI_RESP_OKAY);
		s_axi_wstrb <= 4'he;
		wr(ra(0, PECI_OFS_RISE), 32'hff, PECI_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(ra(0, PECI_OFS_RISE), 8'h00, PECI_RESP_OKAY);
		$display("test reset_and_map done");

		// Master enable stays off here, so flags must set with no interrupt or wake.
		for (int p = 0; p < PECI_NPORT; p++) begin
			re = 8'($urandom);
			fe = 8'($urandom);
			m = PECI_PORT_MASK[p];
			wr(ra(p, PECI_OFS_RISE), {24'h0, re}, PECI_RESP_OKAY);
			wr(ra(p, PECI_OFS_FALL), {24'h0, fe}, PECI_RESP_OKAY);
			rd(ra(p, PECI_OFS_RISE), re & m, PECI_RESP_OKAY);
			rd(ra(p, PECI_OFS_FALL), fe & m, PECI_RESP_OKAY);
			peci_pin_model_inst.drive(p, 8'hff);
			repeat (5) @(posedge aclk);
			rd(ra(p, PECI_OFS_FLAGS), re & m, PECI_RESP_OKAY);
			peci_pin_model_inst.drive(p, 8'h00);
			repeat (5) @(posedge aclk);
			seen = (re | fe) & m;
			rd(ra(p, PECI_OFS_FLAGS), seen, PECI_RESP_OKAY);
			rd(PECI_ADDR_CTRL, {6'h0, |seen, 1'b0}, PECI_RESP_OKAY);
			check("summary", 34'(ioc_summary_flag), 34'(|seen));
			check("irq", 34'(irq), 34'h0);
			wr(ra(p, PECI_OFS_FLAGS), {24'h0, seen & ~seen}, PECI_RESP_OKAY);
			rd(ra(p, PECI_OFS_FLAGS), 8'h00, PECI_RESP_OKAY);
			wr(PECI_ADDR_EVT_CLEAR, 32'hf, PECI_RESP_OKAY);
		end
		check("wake", 34'(wake_count), 34'h0);
		$display("test edges done");

		wr(PECI_ADDR_CTRL, 32'h1, PECI_RESP_OKAY);
		wr(ra(1, PECI_OFS_RISE), 32'hff, PECI_RESP_OKAY);
		w0 = wake_count;
		peci_pin_model_inst.drive(1, 8'hff);
		repeat (5) @(posedge aclk);
		check("irq", 34'(irq), 34'h1);
		check("wake", 34'(wake_count - w0), 34'h1);
		check("summary", 34'(ioc_summary_flag), 34'h1);
		rd(PECI_ADDR_EVT_STATUS, 8'h02, PECI_RESP_OKAY);
		rd(PECI_ADDR_CTRL, 8'h03, PECI_RESP_OKAY);
		wr(PECI_ADDR_EVT_ENABLE, 32'h0, PECI_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check("irq", 34'(irq), 34'h0);
		wr(PECI_ADDR_EVT_ENABLE, 32'hf, PECI_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check("irq", 34'(irq), 34'h1);
		wr(PECI_ADDR_EVT_CLEAR, 32'h2, PECI_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check("irq", 34'(irq), 34'h0);
		rd(PECI_ADDR_EVT_STATUS, 8'h00, PECI_RESP_OKAY);
		wr(ra(1, PECI_OFS_FLAGS), 32'h0, PECI_RESP_OKAY);
		rd(PECI_ADDR_CTRL, 8'h01, PECI_RESP_OKAY);
		check("summary", 34'(ioc_summary_flag), 34'h0);
		$display("test interrupt done");

		// The pin edge is timed so that its flag sets on the edge that performs the write.
		wr(ra(0, PECI_OFS_RISE), 32'h1, PECI_RESP_OKAY);
		peci_pin_model_inst.drive(0, 8'h01);
		@(posedge aclk);
		wr(ra(0, PECI_OFS_FLAGS), 32'h0, PECI_RESP_OKAY);
		rd(ra(0, PECI_OFS_FLAGS), 8'h01, PECI_RESP_OKAY);
		$display("test write_race done");
		repeat (4) @(posedge aclk);
		report_and_stop();
	end
endmodule
